// *** logic/sfs_regs.svh ***
// sfs_regs.svh: opcodes, status fields and limits of the serial memory front end.
// assumes inclusion by bare name from the package; the top module uses its macros without including it.
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// ==========================================================
// opcodes
`define SFS_OP_WREN       8'h06
`define SFS_OP_WL_CLR     8'h04
`define SFS_OP_RDSR       8'h05
`define SFS_OP_WRSR       8'h01
`define SFS_OP_READ       8'h03
`define SFS_OP_WRITE      8'h02

// ==========================================================
// status register fields
`define SFS_ST_WEL        1
`define SFS_ST_BP_LO      2
`define SFS_ST_BP_HI      3
`define SFS_ST_PPE        7
`define SFS_ST_WR_MASK    8'h8c
`define SFS_ST_RESET      8'h00

// ==========================================================
// array layout and protected region bases
`define SFS_ADDR_W        11
`define SFS_DEPTH         2048
`define SFS_QTR_BASE      11'h600
`define SFS_HALF_BASE     11'h400

// ==========================================================
// link limits
`define SFS_SCK_MAX_MHZ   20
`define SFS_CORE_MHZ      250
`define SFS_FIFO_DEPTH    8

`endif

// *** logic/sfs_pkg.sv ***
// sfs_pkg: types shared by the serial memory front end.
// assumes sfs_regs.svh is on the include path.
package sfs_pkg;
    `include "sfs_regs.svh"

    typedef enum logic [2:0] {
        SFS_PH_OP,
        SFS_PH_ADDR_HI,
        SFS_PH_ADDR_LO,
        SFS_PH_DATA,
        SFS_PH_STAT_WR,
        SFS_PH_STAT_RD,
        SFS_PH_IGNORE
    } sfs_phase_t;

    typedef struct packed {
        logic [`SFS_ADDR_W-1:0] addr;
        logic [7:0]             data;
    } sfs_commit_t;
endpackage

// *** logic/sfs_top.sv ***
// sfs_top: spi slave front end of a 2k x 8 serial memory, plus a stream of
// committed writes toward the core clock domain through a small fifo.
// assumes an spi master in mode 0 or 3 and a free running core clock.
//
// What this block does
// [RULE1] select high puts the device in standby, ignoring inputs with output released.
// [RULE2] the master gives a fresh select falling edge before every opcode.
// [RULE3] input bits are captured on serial clock rise, output bits change on its fall.
// [RULE4] the serial clock may run from zero to 20 MHz and pause anywhere with state kept.
// [RULE5] the master should keep the serial input at a valid level at all times.
// [RULE6] the serial output is driven only for read data and released otherwise and in hold.
// [RULE7] with the pin enable bit set and write protect low, status writes are refused.
// [RULE8] hold low freezes the operation and ignores serial clock and select edges.
// [RULE9] the master changes hold only while the serial clock is low.
// [RULE10] only spi modes 0 and 3 are supported.
// [RULE11] the array is 2048 locations of one byte each.
// [RULE12] each data byte is committed on its eighth bit with no busy state.
// [RULE13] a write disable command and quarter, half or full block protection are supported.
// [RULE14] the first byte after select falls is the opcode, then address and data.
// [RULE15] addresses are two bytes of which only the low 11 bits count.
// [RULE16] an unknown opcode makes the device ignore input until the next select fall.
// [RULE17] all bytes move most significant bit first.
`timescale 1ns/1ps

// ==========================================================
// fifo
module sfs_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW:0]      wr_ptr_ff;
    logic [PW:0]      rd_ptr_ff;
    logic [PW:0]      nxt_wr_ptr;
    logic [PW:0]      nxt_rd_ptr;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("sfs_fifo depth must be a power of two");
        end
    end

    assign in_ready_out  = (wr_ptr_ff[PW] == rd_ptr_ff[PW]) || (wr_ptr_ff[PW-1:0] != rd_ptr_ff[PW-1:0]);
    assign out_valid_out = (wr_ptr_ff != rd_ptr_ff);
    assign out_data_out  = mem_ff[rd_ptr_ff[PW-1:0]];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_comb begin
        nxt_wr_ptr = wr_ptr_ff + (PW+1)'(push);
        nxt_rd_ptr = rd_ptr_ff + (PW+1)'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff[PW-1:0]] <= in_data_in;
        end
    end
endmodule

// ==========================================================
// top
module sfs_top #(
    parameter int ADDR_W     = `SFS_ADDR_W,
    parameter int FIFO_DEPTH = `SFS_FIFO_DEPTH
) (
    input  wire logic                core_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                spi_sck_in,
    input  wire logic                spi_cs_n_in,
    input  wire logic                spi_si_in,
    output logic                     spi_so_out,
    output logic                     spi_so_oe_n_out,
    input  wire logic                spi_wp_n_in,
    input  wire logic                spi_hold_n_in,
    output logic                     commit_valid_out,
    input  wire logic                commit_ready_in,
    output sfs_pkg::sfs_commit_t     commit_out,
    output logic                     overflow_out
);
    import sfs_pkg::*;

    initial begin
        if (ADDR_W != `SFS_ADDR_W) begin
            $error("sfs_top serves an 11 bit address only");
        end
    end

    // ======================================================
    // link domain: reset from core crossing, select idle
    logic                   lrst_s1_ff;
    logic                   lrst_s2_ff;
    logic                   link_idle;
    logic [2:0]             cnt_ff;
    logic [2:0]             nxt_cnt;
    logic [6:0]             rx_ff;
    logic [6:0]             nxt_rx;
    sfs_phase_t             phase_ff;
    sfs_phase_t             nxt_phase;
    logic [ADDR_W-1:0]      addr_ff;
    logic [ADDR_W-1:0]      nxt_addr;
    logic [7:0]             tx_ff;
    logic [7:0]             nxt_tx;
    logic                   rd_ff;
    logic                   nxt_rd;
    logic                   wr_ok_ff;
    logic                   nxt_wr_ok;
    logic [7:0]             status_ff;
    logic [7:0]             nxt_status;
    sfs_commit_t            notif_ff;
    sfs_commit_t            nxt_notif;
    logic                   notif_tgl_ff;
    logic                   nxt_notif_tgl;
    logic                   so_ff;
    logic                   drv_ff;
    logic                   nxt_so;
    logic                   nxt_drv;
    logic [7:0]             byte_w;
    logic                   last;
    logic                   mem_we;
    logic                   prot;
    logic [ADDR_W-1:0]      addr_inc;
    logic [7:0]             mem [`SFS_DEPTH];

    // standby clears the transfer and hold freezes it; select only counts outside hold
    assign link_idle = spi_cs_n_in & spi_hold_n_in; // [RULE1] [RULE8] [RULE16]

    always_ff @(posedge spi_sck_in) begin
        lrst_s1_ff <= rst_n_in;
        lrst_s2_ff <= lrst_s1_ff;
    end

    assign byte_w   = {rx_ff, spi_si_in}; // [RULE17]
    assign last     = (cnt_ff == 3'h7);
    assign addr_inc = addr_ff + ADDR_W'(1);

    // block protection by bp field
    always_comb begin
        unique case (status_ff[`SFS_ST_BP_HI:`SFS_ST_BP_LO])
            2'h0: prot = 1'b0;
            2'h1: prot = (addr_ff >= `SFS_QTR_BASE); // [RULE13]
            2'h2: prot = (addr_ff >= `SFS_HALF_BASE); // [RULE13]
            2'h3: prot = 1'b1; // [RULE13]
        endcase
    end

    always_comb begin
        nxt_cnt       = cnt_ff;
        nxt_rx        = rx_ff;
        nxt_phase     = phase_ff;
        nxt_addr      = addr_ff;
        nxt_tx        = tx_ff;
        nxt_rd        = rd_ff;
        nxt_wr_ok     = wr_ok_ff;
        nxt_status    = status_ff;
        nxt_notif     = notif_ff;
        nxt_notif_tgl = notif_tgl_ff;
        mem_we        = 1'b0;
        if (spi_hold_n_in) begin // [RULE8]
            nxt_cnt = cnt_ff + 3'h1;
            nxt_rx  = byte_w[6:0]; // [RULE3]
            nxt_tx  = {tx_ff[6:0], 1'b0}; // [RULE17]
            unique case (phase_ff)
                SFS_PH_OP: begin
                    if (last) begin // [RULE14]
                        nxt_phase = SFS_PH_IGNORE;
                        case (byte_w)
                            `SFS_OP_WREN: nxt_status[`SFS_ST_WEL] = 1'b1;
                            `SFS_OP_WL_CLR: nxt_status[`SFS_ST_WEL] = 1'b0; // [RULE13]
                            `SFS_OP_RDSR: begin
                                nxt_tx    = status_ff;
                                nxt_phase = SFS_PH_STAT_RD;
                            end
                            `SFS_OP_WRSR: begin
                                nxt_wr_ok = status_ff[`SFS_ST_WEL]
                                          & ~(status_ff[`SFS_ST_PPE] & ~spi_wp_n_in); // [RULE7]
                                nxt_status[`SFS_ST_WEL] = 1'b0;
                                nxt_phase = SFS_PH_STAT_WR;
                            end
                            `SFS_OP_READ: begin
                                nxt_rd    = 1'b1;
                                nxt_phase = SFS_PH_ADDR_HI;
                            end
                            `SFS_OP_WRITE: begin
                                nxt_rd    = 1'b0;
                                nxt_wr_ok = status_ff[`SFS_ST_WEL];
                                nxt_status[`SFS_ST_WEL] = 1'b0;
                                nxt_phase = SFS_PH_ADDR_HI;
                            end
                            default: nxt_phase = SFS_PH_IGNORE; // [RULE16]
                        endcase
                    end
                end
                SFS_PH_ADDR_HI: begin
                    if (last) begin
                        nxt_addr[ADDR_W-1:8] = byte_w[ADDR_W-9:0]; // [RULE15]
                        nxt_phase = SFS_PH_ADDR_LO;
                    end
                end
                SFS_PH_ADDR_LO: begin
                    if (last) begin
                        nxt_addr[7:0] = byte_w;
                        nxt_phase     = SFS_PH_DATA;
                        if (rd_ff) begin
                            nxt_tx = mem[{addr_ff[ADDR_W-1:8], byte_w}];
                        end
                    end
                end
                SFS_PH_DATA: begin
                    if (last) begin
                        nxt_addr = addr_inc;
                        if (rd_ff) begin
                            nxt_tx = mem[addr_inc];
                        end else if (wr_ok_ff && !prot) begin
                            mem_we        = 1'b1; // [RULE12]
                            nxt_notif     = '{addr: addr_ff, data: byte_w};
                            nxt_notif_tgl = ~notif_tgl_ff;
                        end
                    end
                end
                SFS_PH_STAT_WR: begin
                    if (last) begin
                        nxt_phase = SFS_PH_IGNORE;
                        if (wr_ok_ff) begin // [RULE7]
                            nxt_status = (status_ff & ~`SFS_ST_WR_MASK)
                                       | (byte_w & `SFS_ST_WR_MASK);
                        end
                    end
                end
                SFS_PH_STAT_RD: begin
                    if (last) begin
                        nxt_tx = status_ff;
                    end
                end
                SFS_PH_IGNORE: begin
                end
            endcase
        end
    end

    // transfer state: cleared when select is released outside hold
    always_ff @(posedge spi_sck_in or posedge link_idle) begin
        if (link_idle) begin // [RULE1] [RULE2]
            cnt_ff   <= 3'h0;
            rx_ff    <= 7'h00;
            phase_ff <= SFS_PH_OP;
            addr_ff  <= '0;
            tx_ff    <= 8'h00;
            rd_ff    <= 1'b0;
            wr_ok_ff <= 1'b0;
        end else begin // [RULE3] [RULE4] [RULE10]
            cnt_ff   <= nxt_cnt;
            rx_ff    <= nxt_rx;
            phase_ff <= nxt_phase;
            addr_ff  <= nxt_addr;
            tx_ff    <= nxt_tx;
            rd_ff    <= nxt_rd;
            wr_ok_ff <= nxt_wr_ok;
        end
    end

    // status and commit notice survive select cycles
    always_ff @(posedge spi_sck_in) begin
        if (!lrst_s2_ff) begin
            status_ff    <= `SFS_ST_RESET;
            notif_ff     <= '0;
            notif_tgl_ff <= 1'b0;
        end else if (!link_idle) begin
            status_ff    <= nxt_status;
            notif_ff     <= nxt_notif;
            notif_tgl_ff <= nxt_notif_tgl;
        end
    end

    always_ff @(posedge spi_sck_in) begin
        if (mem_we && !link_idle) begin
            mem[addr_ff] <= byte_w; // [RULE11] [RULE12]
        end
    end

    // output side: updates on falling serial clock
    always_comb begin
        nxt_so  = so_ff;
        nxt_drv = drv_ff;
        if (spi_hold_n_in) begin
            nxt_so  = tx_ff[7]; // [RULE3] [RULE17]
            nxt_drv = (phase_ff == SFS_PH_STAT_RD) || (phase_ff == SFS_PH_DATA && rd_ff);
        end
    end

    always_ff @(negedge spi_sck_in or posedge link_idle) begin
        if (link_idle) begin
            so_ff  <= 1'b0;
            drv_ff <= 1'b0;
        end else begin
            so_ff  <= nxt_so;
            drv_ff <= nxt_drv;
        end
    end

    assign spi_so_out      = so_ff;
    assign spi_so_oe_n_out = ~(drv_ff & ~spi_cs_n_in & spi_hold_n_in); // [RULE6] [RULE1]

    // ======================================================
    // core domain: toggle crossing of commit notices
    logic        tgl_s1_ff;
    logic        tgl_s2_ff;
    logic        tgl_s3_ff;
    logic        stage_vld_ff;
    logic        nxt_stage_vld;
    sfs_commit_t stage_ff;
    sfs_commit_t nxt_stage;
    logic        ovf_ff;
    logic        nxt_ovf;
    logic        new_evt;
    logic        fifo_in_ready;
    logic        push;
    logic [$bits(sfs_commit_t)-1:0] fifo_out;

    assign new_evt = tgl_s2_ff ^ tgl_s3_ff;
    assign push    = stage_vld_ff & fifo_in_ready;

    always_comb begin
        nxt_stage_vld = stage_vld_ff & ~push;
        nxt_stage     = stage_ff;
        nxt_ovf       = ovf_ff;
        if (new_evt) begin
            // notice holds for a full byte time, far longer than the sync delay
            nxt_stage_vld = 1'b1;
            nxt_stage     = notif_ff;
            nxt_ovf       = ovf_ff | (stage_vld_ff & ~push);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            tgl_s1_ff    <= 1'b0;
            tgl_s2_ff    <= 1'b0;
            tgl_s3_ff    <= 1'b0;
            stage_vld_ff <= 1'b0;
            stage_ff     <= '0;
            ovf_ff       <= 1'b0;
        end else begin
            tgl_s1_ff    <= notif_tgl_ff;
            tgl_s2_ff    <= tgl_s1_ff;
            tgl_s3_ff    <= tgl_s2_ff;
            stage_vld_ff <= nxt_stage_vld;
            stage_ff     <= nxt_stage;
            ovf_ff       <= nxt_ovf;
        end
    end

    sfs_fifo #(
        .WIDTH ($bits(sfs_commit_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (stage_vld_ff),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (stage_ff),
        .out_valid_out (commit_valid_out),
        .out_ready_in  (commit_ready_in),
        .out_data_out  (fifo_out)
    );

    assign commit_out   = sfs_commit_t'(fifo_out);
    assign overflow_out = ovf_ff;
endmodule

// *** dv/sfs_top_monitor.sv ***
// sfs_top_monitor: port-level checks of the serial memory front end.
// assumes binding into sfs_top; all checks run on the core clock.
`timescale 1ns/1ps
module sfs_top_monitor #(
    parameter int ADDR_W     = 11,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic                 core_clk_in,
    input wire logic                 rst_n_in,
    input wire logic                 spi_sck_in,
    input wire logic                 spi_cs_n_in,
    input wire logic                 spi_si_in,
    input wire logic                 spi_so_out,
    input wire logic                 spi_so_oe_n_out,
    input wire logic                 spi_wp_n_in,
    input wire logic                 spi_hold_n_in,
    input wire logic                 commit_valid_out,
    input wire logic                 commit_ready_in,
    input wire sfs_pkg::sfs_commit_t commit_out,
    input wire logic                 overflow_out
);
    import sfs_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ==========================================================
    // sequences
    sequence seq_held;
        !spi_hold_n_in [*2];
    endsequence
    sequence seq_stall;
        commit_valid_out && !commit_ready_in;
    endsequence
    sequence seq_drive;
        (!spi_so_oe_n_out) [*8];
    endsequence

    // ==========================================================
    // assertions
    chk_select_off: assert property (spi_cs_n_in |-> spi_so_oe_n_out)
        else $error("output driven while deselected");
    chk_hold_off: assert property (!spi_hold_n_in |-> spi_so_oe_n_out)
        else $error("output driven during hold");
    chk_so_fall_edge: assert property (!spi_so_oe_n_out && $changed(spi_so_out) |-> !spi_sck_in)
        else $error("output bit changed outside serial clock low phase");
    chk_drive_start: assert property ($fell(spi_so_oe_n_out) |-> !spi_sck_in ##1 seq_drive)
        else $error("read drive not started on a fall or cut short");
    chk_hold_freeze: assert property (seq_held |-> $stable(spi_so_out))
        else $error("output moved while held");
    chk_stall_keeps: assert property (seq_stall |=> commit_valid_out && $stable(commit_out))
        else $error("commit head lost while stalled");
    chk_overflow_sticky: assert property (overflow_out |=> overflow_out)
        else $error("overflow flag cleared");
    chk_overflow_cause: assert property ($rose(overflow_out) |-> $past(commit_valid_out && !commit_ready_in))
        else $error("overflow without a stalled stream");
endmodule

bind sfs_top sfs_top_monitor #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .spi_sck_in(spi_sck_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_si_in(spi_si_in), .spi_so_out(spi_so_out),
    .spi_so_oe_n_out(spi_so_oe_n_out), .spi_wp_n_in(spi_wp_n_in),
    .spi_hold_n_in(spi_hold_n_in), .commit_valid_out(commit_valid_out),
    .commit_ready_in(commit_ready_in), .commit_out(commit_out), .overflow_out(overflow_out)
);

// *** dv/sfs_spi_master.sv ***
// sfs_spi_master: behavioural spi master for the serial memory pins.
// assumes a 48 ns serial clock that stands still between frames.
`timescale 1ns/1ps
module sfs_spi_master (
    output logic     sck_out,
    output logic     cs_n_out,
    output logic     si_out,
    output logic     wp_n_out,
    output logic     hold_n_out,
    input wire logic so_in,
    input wire logic so_oe_n_in
);
    logic mode3 = 1'b0;
    logic so_wire;
    assign so_wire = so_oe_n_in ? 1'b1 : so_in; // released line pulled high
    initial begin
        sck_out    = 1'b0;
        cs_n_out   = 1'b1;
        si_out     = 1'b0;
        wp_n_out   = 1'b1;
        hold_n_out = 1'b1;
    end

    // ==========================================================
    // frame pieces
    task automatic pulses(input int n);
        repeat (n) begin
            #24 sck_out = 1'b1;
            #24 sck_out = 1'b0;
        end
    endtask
    task automatic start();
        sck_out = mode3;
        #24 cs_n_out = 1'b0;
        #24 sck_out = 1'b0;
    endtask
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            si_out = tx[7-i];
            #24 sck_out = 1'b1;
            rx = {rx[6:0], so_wire};
            #24 sck_out = 1'b0;
        end
    endtask
    task automatic stop();
        #24 sck_out = mode3;
        #24 cs_n_out = 1'b1;
        #48;
    endtask
    task automatic frame(input logic [47:0] b, input int n, output logic [7:0] rx);
        start();
        for (int i = n - 1; i >= 0; i--) bits(b[8*i +: 8], 8, rx);
        stop();
    endtask
    // hold with clock and select activity that must be ignored
    task automatic suspend(input int n);
        #24 hold_n_out = 1'b0;
        #24 cs_n_out = 1'b1;
        pulses(n);
        cs_n_out = 1'b0;
        #24 hold_n_out = 1'b1;
    endtask
endmodule

// *** dv/tb.sv ***
// tb: self-checking bench of the serial memory front end.
// assumes the spi master model and the bound checker.
`timescale 1ns/1ps
module tb;
    import sfs_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        ready    = 1'b1;
    logic        sck, cs_n, si, wp_n, hold_n, so, so_oe_n, cvalid, oflow;
    sfs_commit_t commit;
    sfs_commit_t got_q[$];
    sfs_commit_t exp_q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    logic [7:0]  rd;

    always #2 core_clk = ~core_clk;

    sfs_top u_dut (
        .core_clk_in(core_clk), .rst_n_in(rst_n), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
        .spi_si_in(si), .spi_so_out(so), .spi_so_oe_n_out(so_oe_n), .spi_wp_n_in(wp_n),
        .spi_hold_n_in(hold_n), .commit_valid_out(cvalid), .commit_ready_in(ready),
        .commit_out(commit), .overflow_out(oflow)
    );
    sfs_spi_master u_m (
        .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .wp_n_out(wp_n), .hold_n_out(hold_n),
        .so_in(so), .so_oe_n_in(so_oe_n)
    );
    always @(posedge core_clk) begin
        if (rst_n && cvalid === 1'b1 && ready === 1'b1) got_q.push_back(commit);
    end

    // ==========================================================
    // helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_commits();
        repeat (30) @(negedge core_clk);
        cmp(32'(got_q.size()), 32'(exp_q.size()), "commit count");
        foreach (exp_q[i]) if (i < got_q.size()) cmp(32'(got_q[i]), 32'(exp_q[i]), "commit");
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic f(input logic [47:0] b, input int n);
        u_m.frame(b, n, rd);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_latch();
        f(48'h02002011, 4);
        f(48'h06, 1);
        f(48'h04, 1);
        f(48'h02002022, 4);
        cmp_commits();
        f(48'h06, 1);
        f(48'h0500, 2);
        cmp(32'(rd), 32'h02, "latch bit");
        f(48'h04, 1);
    endtask
    task automatic t_write_read();
        f(48'h06, 1);
        f(48'h0207ffa53c, 5);
        exp_q.push_back({11'h7ff, 8'ha5});
        exp_q.push_back({11'h000, 8'h3c});
        cmp_commits();
        f(48'h03f80000, 4);
        cmp(32'(rd), 32'h3c, "read wrap");
        f(48'h03ffff00, 4);
        cmp(32'(rd), 32'ha5, "read top");
    endtask
    task automatic t_status();
        f(48'h06, 1);
        f(48'h0184, 2);
        f(48'h0500, 2);
        cmp(32'(rd), 32'h84, "status");
        u_m.wp_n_out = 1'b0;
        f(48'h06, 1);
        f(48'h0100, 2);
        f(48'h0500, 2);
        cmp(32'(rd), 32'h84, "status locked");
        u_m.wp_n_out = 1'b1;
        for (int bp = 1; bp < 4; bp++) begin
            f(48'h06, 1);
            f({40'h01, 4'h0, 2'(bp), 2'h0}, 2);
            f(48'h06, 1);
            f(48'h0205ff5a, 4);
            f(48'h06, 1);
            f(48'h0203ffc3, 4);
            if (bp == 1) exp_q.push_back({11'h5ff, 8'h5a});
            if (bp != 3) exp_q.push_back({11'h3ff, 8'hc3});
            cmp_commits();
        end
        f(48'h06, 1);
        f(48'h0100, 2);
    endtask
    task automatic t_bad_op();
        f(48'h06, 1);
        f(48'hff02003055, 5);
        cmp(32'(rd), 32'hff, "released out");
        cmp_commits();
        f(48'h04, 1);
    endtask
    task automatic t_hold();
        f(48'h06, 1);
        u_m.start();
        u_m.bits(8'h02, 8, rd);
        u_m.bits(8'h00, 8, rd);
        u_m.bits(8'h40, 8, rd);
        u_m.bits(8'he7, 4, rd);
        #2000;
        u_m.suspend(6);
        u_m.bits(8'h70, 4, rd);
        u_m.stop();
        exp_q.push_back({11'h040, 8'he7});
        cmp_commits();
    endtask
    task automatic t_mode3();
        u_m.mode3 = 1'b1;
        f(48'h03004000, 4);
        cmp(32'(rd), 32'he7, "mode 3 read");
        f(48'h06, 1);
        f(48'h02004118, 4);
        exp_q.push_back({11'h041, 8'h18});
        cmp_commits();
        u_m.mode3 = 1'b0;
    endtask
    task automatic t_overflow();
        @(negedge core_clk) ready = 1'b0;
        f(48'h06, 1);
        u_m.start();
        u_m.bits(8'h02, 8, rd);
        u_m.bits(8'h01, 8, rd);
        u_m.bits(8'h00, 8, rd);
        for (int i = 0; i < 10; i++) u_m.bits(8'(i), 8, rd);
        u_m.stop();
        repeat (30) @(negedge core_clk);
        cmp(32'(oflow), 32'h1, "overflow");
        cmp(32'(cvalid), 32'h1, "full head");
        // staging keeps the newest notice, so the ninth byte is the one lost
        for (int i = 0; i < 8; i++) exp_q.push_back({11'h100 + 11'(i), 8'(i)});
        exp_q.push_back({11'h109, 8'h09});
        ready = 1'b1;
        cmp_commits();
        cmp(32'(cvalid), 32'h0, "drained");
    endtask

    // ==========================================================
    // run control
    task automatic close_out();
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        // status sync reset needs serial clock edges while reset is low
        u_m.pulses(6);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_latch();
        t_write_read();
        t_status();
        t_bad_op();
        t_hold();
        t_mode3();
        t_overflow();
        close_out();
    end
    // about 14k core cycles expected
    initial begin
        #300000;
        mismatches++;
        close_out();
    end
endmodule
